// *** core/chs_charger_regs.sv ***
/*
 * Charger setting registers behind a two-wire serial slave, with decoding
 * of charge current, finish current and battery target, plus the
 * deglitch timing enable.
 * Assumes scl/sda arrive from pins with an external pull-up; the wire
 * level is resolved outside from sda_drive_b.
 */
`timescale 1ns/1ps
`default_nettype none
`include "chs_defines.svh"

module chs_charger_regs
  import chs_pkg::*;
#(
  parameter logic [6:0] BUS_ADDRESS = `CHS_BUS_ADDRESS,
  parameter int TICK_CYCLES = `CHS_DEGLITCH_TICK_CYCLES
) (
  input wire logic core_clk, // 50 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_drive_b, // low pulls sda low
  input wire logic external_charge_set_pin, // charge resistor fitted
  input wire logic external_finish_set_pin, // finish resistor fitted
  input wire logic input_voltage_loop, // input voltage loop in control
  input wire logic thermistor_sense, // thermistor in cool band
  input wire logic battery_active, // running from battery
  input wire logic supply_present, // input supply present
  output logic [8:0] charge_current_ma, // effective charge current
  output logic charge_from_external_set, // charge current from resistor
  output logic charger_halt, // charging stopped
  output logic high_impedance_on, // high-impedance mode
  output logic [15:0] finish_current_ua, // effective finish current
  output logic finish_from_external_set, // finish current from resistor
  output logic finish_cutoff_allowed, // termination may act now
  output logic [12:0] battery_target_mv, // effective regulation target
  output logic deglitch_tick // fault deglitch time base pulse
);

  // last divider count; the divider is six bits, so tick periods of up
  // to 64 clocks are covered, which includes the 1 us default
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

  // whole state and its next value, plus synchronised pin levels
  chs_regs_type st_reg;
  chs_regs_type st_next;
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic vloop_s;
  logic cool_s;
  logic bat_s;
  logic supply_s;

  // all pin levels but the two set-resistor pins pass two flops; the bus lines go through inverted so
  // the low reset of the synchroniser reads as an idle high bus
  chs_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({~scl_in, ~sda_in, input_voltage_loop, thermistor_sense,
      battery_active, supply_present}),
    .sync_out(pins_s)
  );

  // undo the inversion; matches the high reset of the edge memories
  assign scl_s = !pins_s[5];
  assign sda_s = !pins_s[4];
  assign {vloop_s, cool_s, bat_s, supply_s} = pins_s[3:0];

  // register read multiplexer; unmapped offsets read zero
  // used both for the first byte of a read and for every later one
  function automatic logic [7:0] read_mux(input chs_regs_type s, input logic [7:0] ofs);
    case (ofs)
      `CHS_OFS_FAST_CHARGE: read_mux = s.fast_reg;
      `CHS_OFS_FINISH: read_mux = s.finish_reg;
      `CHS_OFS_BATTERY: read_mux = s.battery_reg;
      `CHS_OFS_SYS_OUT: read_mux = s.sys_out_reg;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // next state: serial slave, register writes, decoders, tick divider
  always_comb begin
    // locals are cleared first so no path leaves them open
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [4:0] ccode;
    logic [4:0] fcode;
    logic [6:0] bcode;
    logic [12:0] bat_mv;
    logic tick_run;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    ccode = 5'h00;
    fcode = 5'h00;
    bcode = 7'h00;
    bat_mv = 13'h0000;
    tick_run = 1'b0;
    st_next = st_reg;
    st_next.scl_prev = scl_s;
    st_next.sda_prev = sda_s;
    scl_rise = scl_s && !st_reg.scl_prev;
    scl_fall = !scl_s && st_reg.scl_prev;
    start_seen = scl_s && st_reg.scl_prev && st_reg.sda_prev && !sda_s;
    stop_seen = scl_s && st_reg.scl_prev && !st_reg.sda_prev && sda_s;

    // serial slave sequencing; start and stop win over any byte in flight,
    // so a master may abandon a transfer at any point
    if (start_seen) begin
      st_next.state = st_addr;
      st_next.bit_cnt = 4'h0;
      st_next.first_byte = 1'b1;
      st_next.sda_drive_b = 1'b1;
    end else if (stop_seen) begin
      st_next.state = st_idle;
      st_next.sda_drive_b = 1'b1;
    end else begin
      case (st_reg.state)
        st_idle: begin
          // idle only waits for a start, with the data line released
          st_next.sda_drive_b = 1'b1;
        end
        st_addr, st_wbyte: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], sda_s};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end else if (scl_fall && st_reg.bit_cnt == 4'h8) begin
            // the eighth falling edge ends the byte; the answer goes out
            // while the clock is low, ahead of the ninth rising edge
            st_next.bit_cnt = 4'h0;
            if (st_reg.state == st_addr) begin
              if (st_reg.shift[7:1] == BUS_ADDRESS) begin
                st_next.sda_drive_b = 1'b0;
                st_next.is_read = st_reg.shift[0];
                st_next.state = st_addr_ack;
              end else begin
                st_next.state = st_idle;
              end
            end else begin
              st_next.sda_drive_b = 1'b0;
              st_next.state = st_wack;
              st_next.first_byte = 1'b0;
              if (st_reg.first_byte) begin
                st_next.pointer = st_reg.shift;
              end else begin
                st_next.pointer = st_reg.pointer + 8'h01;
                // the pointer moves on over unmapped offsets too; their data drops
                case (st_reg.pointer)
                  `CHS_OFS_FAST_CHARGE: begin
                    st_next.fast_reg = st_reg.shift;
                    st_next.charge_written = 1'b1;
                  end
                  `CHS_OFS_FINISH: begin
                    st_next.finish_reg = st_reg.shift;
                    st_next.finish_written = 1'b1;
                  end
                  `CHS_OFS_BATTERY: st_next.battery_reg = st_reg.shift;
                  `CHS_OFS_SYS_OUT: st_next.sys_out_reg = st_reg.shift;
                  default: st_next.pointer = st_reg.pointer + 8'h01;
                endcase
              end
            end
          end
        end
        st_addr_ack: begin
          // after the address answer the slave either sends or listens
          if (scl_fall) begin
            if (st_reg.is_read) begin
              st_next.shift = read_mux(st_reg, st_reg.pointer);
              st_next.sda_drive_b = st_next.shift[7];
              st_next.state = st_rbyte;
            end else begin
              st_next.sda_drive_b = 1'b1;
              st_next.state = st_wbyte;
            end
          end
        end
        st_wack: begin
          // hold the acknowledge until the clock falls again
          if (scl_fall) begin
            st_next.sda_drive_b = 1'b1;
            st_next.state = st_wbyte;
          end
        end
        st_rbyte: begin
          // after the eighth bit the line is freed for the master's answer
          if (scl_fall) begin
            if (st_reg.bit_cnt == 4'h7) begin
              st_next.bit_cnt = 4'h0;
              st_next.sda_drive_b = 1'b1;
              st_next.pointer = st_reg.pointer + 8'h01;
              st_next.state = st_rack;
            end else begin
              st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sda_drive_b = st_reg.shift[6];
            end
          end
        end
        st_rack: begin
          // the master's answer is taken at the rise and acted on at the fall
          if (scl_rise) begin
            st_next.master_ack = !sda_s;
          end else if (scl_fall) begin
            if (st_reg.master_ack) begin
              st_next.shift = read_mux(st_reg, st_reg.pointer);
              st_next.sda_drive_b = st_next.shift[7];
              st_next.state = st_rbyte;
            end else begin
              st_next.state = st_idle;
            end
          end
        end
        default: begin
          st_next.state = st_idle;
          st_next.sda_drive_b = 1'b1;
        end
      endcase
    end

    // charge current decode; an all-ones code reports the clamped figure
    // but hands control to the set resistor through the flag, and the
    // resistor pin only counts until software writes the register
    ccode = st_reg.fast_reg[`CHS_CODE_MSB:`CHS_CODE_LSB];
    st_next.charge_from_external_set = (ccode == 5'h1f) ||
      (external_charge_set_pin && !st_reg.charge_written);
    if (!st_reg.fast_reg[`CHS_BIT_RANGE]) begin
      st_next.charge_current_ma = `CHS_CHG_LOW_BASE_MA + 9'(ccode);
      if (st_next.charge_current_ma > `CHS_CHG_LOW_MAX_MA) begin
        st_next.charge_current_ma = `CHS_CHG_LOW_MAX_MA;
      end
    end else begin
      st_next.charge_current_ma = `CHS_CHG_HIGH_BASE_MA +
        9'(ccode) * `CHS_CHG_HIGH_STEP_MA;
      if (st_next.charge_current_ma > `CHS_CHG_HIGH_MAX_MA) begin
        st_next.charge_current_ma = `CHS_CHG_HIGH_MAX_MA;
      end
    end
    // disable and high-impedance bits pass straight through
    st_next.charger_halt = st_reg.fast_reg[`CHS_BIT_CHARGE_OFF];
    st_next.high_impedance_on = st_reg.fast_reg[`CHS_BIT_HIGH_Z];

    // finish current decode; only the low range can overshoot its
    // ceiling, the high range tops out at 37 mA by itself
    fcode = st_reg.finish_reg[`CHS_CODE_MSB:`CHS_CODE_LSB];
    st_next.finish_from_external_set = external_finish_set_pin &&
      !st_reg.finish_written;
    if (!st_reg.finish_reg[`CHS_BIT_RANGE]) begin
      st_next.finish_current_ua = `CHS_FIN_LOW_STEP_UA +
        16'(fcode) * `CHS_FIN_LOW_STEP_UA;
      if (st_next.finish_current_ua > `CHS_FIN_LOW_MAX_UA) begin
        st_next.finish_current_ua = `CHS_FIN_LOW_MAX_UA;
      end
    end else begin
      st_next.finish_current_ua = `CHS_FIN_HIGH_BASE_UA +
        16'(fcode) * `CHS_FIN_HIGH_STEP_UA;
    end
    // termination is vetoed while the input or thermistor loop has control
    st_next.finish_cutoff_allowed = st_reg.finish_reg[`CHS_BIT_CUTOFF_ON] &&
      !vloop_s && !cool_s;

    // battery target decode; seven bits reach 4.27 V at most, so the
    // ceiling only guards against a wider code field
    bcode = st_reg.battery_reg[`CHS_BAT_MSB:`CHS_BAT_LSB];
    bat_mv = `CHS_BAT_BASE_MV + 13'(bcode) * `CHS_BAT_STEP_MV;
    st_next.battery_target_mv = (bat_mv > `CHS_BAT_MAX_MV) ? `CHS_BAT_MAX_MV :
      bat_mv;

    // deglitch time base, held in high-impedance mode to save power unless the supply is present or the bus is busy on battery;
    // the divider keeps its count while held, so the first tick after it
    // resumes comes early, after only the remaining count
    tick_run = !st_reg.fast_reg[`CHS_BIT_HIGH_Z] || supply_s ||
      (bat_s && st_reg.state != st_idle);
    st_next.deglitch_tick = 1'b0;
    if (tick_run) begin
      if (st_reg.div_cnt >= TICK_LAST) begin
        st_next.div_cnt = 6'h00;
        st_next.deglitch_tick = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 6'h01;
      end
    end
  end

  // state register with reset values; decoded outputs read zero for the
  // reset cycle and show the decoded reset settings one clock later
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.fast_reg <= `CHS_RST_FAST_CHARGE;
      st_reg.finish_reg <= `CHS_RST_FINISH;
      st_reg.battery_reg <= `CHS_RST_BATTERY;
      st_reg.sys_out_reg <= `CHS_RST_SYS_OUT;
      st_reg.state <= st_idle;
      st_reg.scl_prev <= 1'b1;
      st_reg.sda_prev <= 1'b1;
      st_reg.sda_drive_b <= 1'b1;
      st_reg.charge_current_ma <= 9'h000;
      st_reg.finish_current_ua <= 16'h0000;
      st_reg.battery_target_mv <= 13'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  // no logic sits between a flop and a pin
  assign sda_drive_b = st_reg.sda_drive_b;
  assign charge_current_ma = st_reg.charge_current_ma;
  assign charge_from_external_set = st_reg.charge_from_external_set;
  assign charger_halt = st_reg.charger_halt;
  assign high_impedance_on = st_reg.high_impedance_on;
  assign finish_current_ua = st_reg.finish_current_ua;
  assign finish_from_external_set = st_reg.finish_from_external_set;
  assign finish_cutoff_allowed = st_reg.finish_cutoff_allowed;
  assign battery_target_mv = st_reg.battery_target_mv;
  assign deglitch_tick = st_reg.deglitch_tick;

endmodule : chs_charger_regs

`default_nettype wire

// *** core/chs_defines.svh ***
/*
 * Constants for the charger setting registers: offsets, reset values,
 * field positions and timing counts.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef CHS_DEFINES_SVH
`define CHS_DEFINES_SVH

// register offsets
`define CHS_OFS_FAST_CHARGE 8'h03
`define CHS_OFS_FINISH 8'h04
`define CHS_OFS_BATTERY 8'h05
`define CHS_OFS_SYS_OUT 8'h06

// reset values
`define CHS_RST_FAST_CHARGE 8'h14
`define CHS_RST_FINISH 8'h0e
`define CHS_RST_BATTERY 8'h78
`define CHS_RST_SYS_OUT 8'haa

// field positions
`define CHS_BIT_RANGE 7
`define CHS_CODE_MSB 6
`define CHS_CODE_LSB 2
`define CHS_BIT_CHARGE_OFF 1
`define CHS_BIT_HIGH_Z 0
`define CHS_BIT_CUTOFF_ON 1
`define CHS_BAT_MSB 7
`define CHS_BAT_LSB 1

// decoding figures
`define CHS_CHG_LOW_BASE_MA 9'd5
`define CHS_CHG_LOW_MAX_MA 9'd35
`define CHS_CHG_HIGH_BASE_MA 9'd40
`define CHS_CHG_HIGH_STEP_MA 9'd10
`define CHS_CHG_HIGH_MAX_MA 9'd300
`define CHS_FIN_LOW_STEP_UA 16'd500
`define CHS_FIN_LOW_MAX_UA 16'd5000
`define CHS_FIN_HIGH_BASE_UA 16'd6000
`define CHS_FIN_HIGH_STEP_UA 16'd1000
`define CHS_BAT_BASE_MV 13'd3000
`define CHS_BAT_STEP_MV 13'd10
`define CHS_BAT_MAX_MV 13'd4650

// timing
`define CHS_CLK_PERIOD_NS 20
`define CHS_DEGLITCH_TICK_NS 1000
`define CHS_DEGLITCH_TICK_CYCLES (`CHS_DEGLITCH_TICK_NS / `CHS_CLK_PERIOD_NS)

// bus address of this device (value arbitrary)
`define CHS_BUS_ADDRESS 7'h42

`endif

// *** core/chs_pkg.sv ***
/*
 * Types for the charger setting registers: serial slave states and the
 * packed state record of the main module.
 * Assumes chs_defines.svh is on the include path.
 */
`include "chs_defines.svh"

package chs_pkg;

  // serial slave states, one-hot
  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_addr = 7'b0000010,
    st_addr_ack = 7'b0000100,
    st_wbyte = 7'b0001000,
    st_wack = 7'b0010000,
    st_rbyte = 7'b0100000,
    st_rack = 7'b1000000
  } chs_state_type;

  // whole state of the main module
  typedef struct packed {
    logic [7:0] fast_reg;
    logic [7:0] finish_reg;
    logic [7:0] battery_reg;
    logic [7:0] sys_out_reg;
    logic charge_written;
    logic finish_written;
    chs_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic is_read;
    logic first_byte;
    logic master_ack;
    logic scl_prev;
    logic sda_prev;
    logic sda_drive_b;
    logic [5:0] div_cnt;
    logic deglitch_tick;
    logic [8:0] charge_current_ma;
    logic charge_from_external_set;
    logic charger_halt;
    logic high_impedance_on;
    logic [15:0] finish_current_ua;
    logic finish_from_external_set;
    logic finish_cutoff_allowed;
    logic [12:0] battery_target_mv;
  } chs_regs_type;

endpackage : chs_pkg

// *** core/chs_sync.sv ***
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes inputs are levels from outside the core_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module chs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : chs_sync

`default_nettype wire

// *** tb/chs_charger_regs_properties.sv ***
/* checker for the charger setting registers: relations between outputs.
   assumes TICK_CYCLES above 1; bound to the top module by name. */
`timescale 1ns/1ps
`default_nettype none
module chs_charger_regs_checker (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic sda_drive_b, // data pull
  input wire logic input_voltage_loop, // loop
  input wire logic thermistor_sense, // cool
  input wire logic battery_active, // battery
  input wire logic supply_present, // supply
  input wire logic [8:0] charge_current_ma, // charge
  input wire logic charge_from_external_set, // ext charge
  input wire logic charger_halt, // halt
  input wire logic high_impedance_on, // high z
  input wire logic [15:0] finish_current_ua, // finish
  input wire logic finish_from_external_set, // ext finish
  input wire logic finish_cutoff_allowed, // cutoff
  input wire logic [12:0] battery_target_mv, // target
  input wire logic deglitch_tick // tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // decoded settings stay on their grids and below their ceilings
  chk_charge_grid: assert property ($past(rst_b) && !charge_from_external_set |->
    (charge_current_ma >= 9'd5 && charge_current_ma <= 9'd35) ||
    (charge_current_ma >= 9'd40 && charge_current_ma % 10 == 0))
    else $error("charge current off grid");
  chk_charge_clamp: assert property ($past(rst_b) |-> charge_current_ma <= 9'd300)
    else $error("charge current above ceiling");
  chk_finish_grid: assert property ($past(rst_b) && !finish_from_external_set |->
    finish_current_ua % 500 == 0 && finish_current_ua >= 16'd500 &&
    finish_current_ua <= 16'd37000)
    else $error("finish current off grid");
  chk_finish_low_clamp: assert property (!(finish_current_ua > 16'd5000 &&
    finish_current_ua < 16'd6000))
    else $error("finish current not clamped");
  chk_target_range: assert property ($past(rst_b) |-> battery_target_mv >= 13'd3000 &&
    battery_target_mv <= 13'd4650 && battery_target_mv % 10 == 0)
    else $error("target voltage out of range");
  // termination blocked while another loop rules
  chk_loop_cutoff: assert property ((input_voltage_loop || thermistor_sense)[*4] |=>
    !finish_cutoff_allowed)
    else $error("cutoff allowed while loop active");
  // deglitch time base, then idle outputs after reset
  chk_tick_pulse: assert property (deglitch_tick |=> !deglitch_tick)
    else $error("tick longer than one cycle");
  chk_tick_halted: assert property ((high_impedance_on && !supply_present &&
    !battery_active)[*6] |-> !deglitch_tick)
    else $error("tick in high impedance mode");
  chk_tick_supply: assert property (supply_present[*8] |-> ##[0:60] deglitch_tick)
    else $error("tick missing with supply");
  chk_reset_idle: assert property ($rose(rst_b) |-> sda_drive_b && !charger_halt &&
    !high_impedance_on)
    else $error("outputs not idle after reset");
  cover property (deglitch_tick);
  cover property (charge_from_external_set);
  cover property (!sda_drive_b);
endmodule : chs_charger_regs_checker
bind chs_charger_regs chs_charger_regs_checker chs_charger_regs_checker_inst (
  .core_clk, .rst_b, .sda_drive_b, .input_voltage_loop, .thermistor_sense,
  .battery_active, .supply_present, .charge_current_ma, .charge_from_external_set,
  .charger_halt, .high_impedance_on, .finish_current_ua, .finish_from_external_set,
  .finish_cutoff_allowed, .battery_target_mv, .deglitch_tick);
`default_nettype wire

// *** tb/chs_charger_regs_tb.sv ***
/* testbench for the charger setting registers: a bit-banged two-wire
   master reaches the registers; decoded outputs are judged.
   assumes an open-drain data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
`include "chs_defines.svh"
module chs_charger_regs_tb;
  localparam logic [6:0] ADDR = 7'h35; // arbitrary bus address
  logic core_clk, rst_b, scl_m, sda_m, ext_chg, ext_fin, vloop, tsense, bat_act, sup;
  logic sda_drive_b, charge_from_external_set, charger_halt, high_impedance_on;
  logic finish_from_external_set, finish_cutoff_allowed, deglitch_tick;
  logic [8:0] charge_current_ma;
  logic [15:0] finish_current_ua;
  logic [12:0] battery_target_mv;
  wire logic sda_w;
  int miscompares, cmp_count;
  // pulled-up data wire, low when any party pulls
  assign sda_w = sda_m & sda_drive_b;
  chs_charger_regs #(.BUS_ADDRESS(ADDR), .TICK_CYCLES(4)) chs_charger_regs_inst (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_m), .sda_in(sda_w),
    .sda_drive_b(sda_drive_b), .external_charge_set_pin(ext_chg),
    .external_finish_set_pin(ext_fin), .input_voltage_loop(vloop),
    .thermistor_sense(tsense), .battery_active(bat_act), .supply_present(sup),
    .charge_current_ma(charge_current_ma), .charge_from_external_set(charge_from_external_set),
    .charger_halt(charger_halt), .high_impedance_on(high_impedance_on),
    .finish_current_ua(finish_current_ua), .finish_from_external_set(finish_from_external_set),
    .finish_cutoff_allowed(finish_cutoff_allowed), .battery_target_mv(battery_target_mv),
    .deglitch_tick(deglitch_tick));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic hp;
    repeat (6) @(negedge core_clk);
  endtask : hp
  // one bit: data set while the clock is low, sampled at the end of high
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    hp;
    scl_m = 1'b1;
    hp;
    s = sda_w;
    scl_m = 1'b0;
    hp;
  endtask : bit_io
  task automatic start_c;
    sda_m = 1'b1;
    hp;
    scl_m = 1'b1;
    hp;
    sda_m = 1'b0;
    hp;
    scl_m = 1'b0;
    hp;
  endtask : start_c
  task automatic stop_c;
    sda_m = 1'b0;
    hp;
    scl_m = 1'b1;
    hp;
    sda_m = 1'b1;
    hp;
  endtask : stop_c
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // read one byte and end the read with a nack
  task automatic rbyte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
  endtask : rbyte
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic a;
    start_c;
    wbyte({ADDR, 1'b0}, a);
    chk("address ack", 1, 32'(a));
    wbyte(ofs, a);
    wbyte(v, a);
    stop_c;
  endtask : wr
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start_c;
    wbyte({ADDR, 1'b0}, a);
    wbyte(ofs, a);
    start_c;
    wbyte({ADDR, 1'b1}, a);
    rbyte(d);
    stop_c;
  endtask : rd
  task automatic cnt(output int n);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (deglitch_tick === 1'b1) n++;
    end
  endtask : cnt
  task automatic t_reset;
    logic [7:0] rv [4] = '{`CHS_RST_FAST_CHARGE, `CHS_RST_FINISH, `CHS_RST_BATTERY,
      `CHS_RST_SYS_OUT};
    logic [7:0] d;
    logic a;
    chk("charge ma", 10, 32'(charge_current_ma));
    chk("finish ua", 2000, 32'(finish_current_ua));
    chk("target mv", 3600, 32'(battery_target_mv));
    chk("cutoff", 1, 32'(finish_cutoff_allowed));
    chk("finish ext", 1, 32'(finish_from_external_set));
    chk("charge ext", 1, 32'(charge_from_external_set));
    for (int i = 0; i < 4; i++) begin
      rd(8'(3 + i), d);
      chk("reset value", 32'(rv[i]), 32'(d));
    end
    wr(8'h10, 8'h5a);
    rd(8'h10, d);
    chk("unmapped read", 0, 32'(d));
    start_c;
    wbyte({7'h36, 1'b0}, a);
    chk("foreign ack", 0, 32'(a));
    stop_c;
  endtask : t_reset
  task automatic t_finish;
    logic [7:0] v [7] = '{8'h06, 8'h26, 8'h2a, 8'h7e, 8'h82, 8'hfe, 8'hfd};
    int ua [7] = '{1000, 5000, 5000, 5000, 6000, 37000, 37000};
    for (int i = 0; i < 7; i++) begin
      wr(`CHS_OFS_FINISH, v[i]);
      chk("finish ua", ua[i], 32'(finish_current_ua));
      chk("cutoff", 32'(v[i][1]), 32'(finish_cutoff_allowed));
      chk("finish ext", 0, 32'(finish_from_external_set));
    end
    wr(`CHS_OFS_FINISH, 8'h0e);
    tsense = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("cutoff cool", 0, 32'(finish_cutoff_allowed));
    tsense = 1'b0;
    vloop = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("cutoff loop", 0, 32'(finish_cutoff_allowed));
    vloop = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("cutoff free", 1, 32'(finish_cutoff_allowed));
  endtask : t_finish
  task automatic t_charge;
    logic [7:0] v [8] = '{8'h00, 8'h76, 8'h78, 8'h81, 8'he8, 8'hec, 8'h7c, 8'hfc};
    int ma [8] = '{5, 34, 35, 40, 300, 300, 0, 0};
    wr(`CHS_OFS_FINISH, 8'h04);
    for (int i = 0; i < 8; i++) begin
      wr(`CHS_OFS_FAST_CHARGE, v[i]);
      chk("charge ext", 32'(v[i][6:2] == 5'h1f), 32'(charge_from_external_set));
      if (i < 6) chk("charge ma", ma[i], 32'(charge_current_ma));
      chk("halt", 32'(v[i][1]), 32'(charger_halt));
      chk("high z", 32'(v[i][0]), 32'(high_impedance_on));
    end
  endtask : t_charge
  task automatic t_battery;
    logic [7:0] v [4] = '{8'h00, 8'hd3, 8'hff, 8'h78};
    int mv [4] = '{3000, 4050, 4270, 3600};
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      wr(`CHS_OFS_BATTERY, v[i]);
      chk("target mv", mv[i], 32'(battery_target_mv));
      rd(`CHS_OFS_BATTERY, d);
      chk("battery readback", 32'(v[i]), 32'(d));
    end
  endtask : t_battery
  task automatic t_deglitch;
    int n;
    wr(`CHS_OFS_FAST_CHARGE, 8'h14);
    cnt(n);
    chk("ticks run", 1, 32'(n >= 9 && n <= 11));
    wr(`CHS_OFS_FAST_CHARGE, 8'h15);
    repeat (10) @(negedge core_clk);
    cnt(n);
    chk("ticks high z", 0, n);
    sup = 1'b1;
    repeat (6) @(negedge core_clk);
    cnt(n);
    chk("ticks supply", 1, 32'(n >= 9 && n <= 11));
    sup = 1'b0;
    bat_act = 1'b1;
    repeat (10) @(negedge core_clk);
    cnt(n);
    chk("ticks battery idle", 0, n);
    start_c;
    cnt(n);
    chk("ticks battery bus", 1, 32'(n >= 8));
    stop_c;
    bat_act = 1'b0;
  endtask : t_deglitch
  // main sequence
  initial begin
    rst_b = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    ext_chg = 1'b1;
    ext_fin = 1'b1;
    vloop = 1'b0;
    tsense = 1'b0;
    bat_act = 1'b0;
    sup = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset;
    t_finish;
    t_charge;
    t_battery;
    t_deglitch;
    summarize;
  end
  // watchdog against a hung bus
  initial begin
    repeat (50000) @(posedge core_clk);
    miscompares++;
    $display("MISMATCH watchdog expected done seen hang");
    summarize;
  end
endmodule : chs_charger_regs_tb
`default_nettype wire
